//--- logic/mirb_bank.sv
/*
  Interrupt register bank: edge select, three primary control registers
  and three group registers, request flags, enables, global enable and
  a one-deep vector request to the core.
  Assumes event inputs are one-cycle pulses from same-clock logic and
  external pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mirb_consts.svh"

module mirb_bank #(
  parameter int HAS_UART = 0
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [2:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_wdata,
  output var  logic [7:0]        o_reg_rdata,
  input  wire logic              i_ext_pin_a,
  input  wire logic              i_ext_pin_b,
  input  wire logic [1:0]        i_tick_evt,
  input  wire logic              i_adc_evt,
  input  wire logic              i_nvm_evt,
  input  wire logic              i_serial_evt,
  input  wire logic              i_uart_evt,
  input  wire logic [11:0]       i_group_evt,
  input  wire logic              i_svc_ack,
  output var  logic              o_irq_req,
  output var  mirb_pkg::mirb_src_t o_irq_id
);
  import mirb_pkg::*;

  // only the small and the full variant exist
  if (HAS_UART != 0 && HAS_UART != 1) begin : g_bad_uart
    $error("HAS_UART must be 0 or 1");
  end

  mirb_byte_t regs_q [`MIRB_NUM_REGS];
  mirb_byte_t regs_d [`MIRB_NUM_REGS];
  mirb_byte_t set_w  [`MIRB_NUM_REGS];
  mirb_byte_t clr_w  [`MIRB_NUM_REGS];
  mirb_byte_t rdata_q;
  logic       req_q;
  mirb_src_t  id_q;

  mirb_edge_if edge_a ();
  mirb_edge_if edge_b ();

  mirb_edge_det u_det_a (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ext_pin_a),
    .io_edge   (edge_a)
  );
  mirb_edge_det u_det_b (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ext_pin_b),
    .io_edge   (edge_b)
  );

  // implemented bits of each register
  function automatic mirb_byte_t reg_mask(input logic [2:0] idx);
    mirb_byte_t m;
    m = `MIRB_MASK_FULL;
    if (idx == `MIRB_REG_EDGE) begin
      m = `MIRB_MASK_EDGE;
    end else if (idx == `MIRB_REG_CTRL_A) begin
      m = `MIRB_MASK_CTRL_A;
    end else if (idx == `MIRB_REG_CTRL_C && HAS_UART == 0) begin
      m = `MIRB_MASK_C_SMALL;
    end
    return m;
  endfunction : reg_mask

  // sub-event flags of a group register, set whatever the enables
  function automatic mirb_byte_t group_set(input logic [3:0] evt);
    mirb_byte_t s;
    s = {evt, 4'h0};
    return s;
  endfunction : group_set

  function automatic logic group_hit(input logic [3:0] evt, input mirb_byte_t r);
    return |(evt & r[3:0]);
  endfunction : group_hit

  // register and bit that hold a source's request flag
  function automatic logic [2:0] src_reg(input mirb_src_t s);
    logic [2:0] r;
    case (s)
      MIRB_SRC_PIN_A, MIRB_SRC_TICK_A, MIRB_SRC_TICK_B: r = `MIRB_REG_CTRL_A;
      MIRB_SRC_PIN_B, MIRB_SRC_GROUP0, MIRB_SRC_ADC, MIRB_SRC_NVM: r = `MIRB_REG_CTRL_B;
      default: r = `MIRB_REG_CTRL_C;
    endcase
    return r;
  endfunction : src_reg

  function automatic mirb_byte_t src_bit(input mirb_src_t s);
    mirb_byte_t b;
    case (s)
      MIRB_SRC_PIN_A:  b = 8'(1 << `MIRB_PIN_A_FLAG);
      MIRB_SRC_TICK_A: b = 8'(1 << `MIRB_TICK_A_FLAG);
      MIRB_SRC_TICK_B: b = 8'(1 << `MIRB_TICK_B_FLAG);
      MIRB_SRC_PIN_B:  b = 8'(1 << `MIRB_PIN_B_FLAG);
      MIRB_SRC_GROUP0: b = 8'(1 << `MIRB_GROUP0_FLAG);
      MIRB_SRC_ADC:    b = 8'(1 << `MIRB_ADC_FLAG);
      MIRB_SRC_NVM:    b = 8'(1 << `MIRB_NVM_FLAG);
      MIRB_SRC_GROUP1: b = 8'(1 << `MIRB_GROUP1_FLAG);
      MIRB_SRC_GROUP2: b = 8'(1 << `MIRB_GROUP2_FLAG);
      MIRB_SRC_SERIAL: b = 8'(1 << `MIRB_SERIAL_FLAG);
      default:         b = 8'(1 << `MIRB_UART_FLAG);
    endcase
    return b;
  endfunction : src_bit

  // lowest index wins
  function automatic mirb_src_t first_src(input logic [10:0] p);
    mirb_src_t s;
    s = MIRB_SRC_PIN_A;
    for (int i = 10; i >= 0; i--) begin
      if (p[i]) begin
        s = mirb_src_t'(4'(i));
      end
    end
    return s;
  endfunction : first_src

  wire mirb_byte_t ctrl_a_w = regs_q[`MIRB_REG_CTRL_A];
  wire mirb_byte_t ctrl_b_w = regs_q[`MIRB_REG_CTRL_B];
  wire mirb_byte_t ctrl_c_w = regs_q[`MIRB_REG_CTRL_C];
  wire logic       global_irq_en = ctrl_a_w[`MIRB_GLOBAL_EN];
  wire logic       svc_take = i_svc_ack & req_q;
  wire logic [3:0] grp_a_evt = i_group_evt[3:0];
  wire logic [3:0] grp_b_evt = i_group_evt[7:4];
  wire logic [3:0] grp_c_evt = i_group_evt[11:8];
  wire logic       grp0_hit = group_hit(grp_a_evt, regs_q[`MIRB_REG_GRP_A]);
  wire logic       grp1_hit = group_hit(grp_b_evt, regs_q[`MIRB_REG_GRP_B]);
  wire logic       grp2_hit = group_hit(grp_c_evt, regs_q[`MIRB_REG_GRP_C]);
  wire logic       uart_ok  = (HAS_UART != 0);

  assign edge_a.sel = regs_q[`MIRB_REG_EDGE][`MIRB_PIN_A_SEL_LSB +: 2];  // R3
  assign edge_b.sel = regs_q[`MIRB_REG_EDGE][`MIRB_PIN_B_SEL_LSB +: 2];  // R2

  // hardware set terms
  assign set_w[`MIRB_REG_EDGE] = 8'h00;
  assign set_w[`MIRB_REG_CTRL_A] = 8'({i_tick_evt[1], i_tick_evt[0], edge_a.pulse})
                                   << `MIRB_PIN_A_FLAG;  // R1 R5 R6 R16
  assign set_w[`MIRB_REG_CTRL_B] = 8'({edge_b.pulse, i_adc_evt, i_nvm_evt, grp0_hit})
                                   << `MIRB_GROUP0_FLAG;  // R1 R7 R8 R9 R10 R16
  assign set_w[`MIRB_REG_CTRL_C] = 8'({i_uart_evt & uart_ok, i_serial_evt, grp2_hit, grp1_hit})
                                   << `MIRB_GROUP1_FLAG;  // R1 R11 R12 R13 R16
  assign set_w[`MIRB_REG_GRP_A] = group_set(grp_a_evt);
  assign set_w[`MIRB_REG_GRP_B] = group_set(grp_b_evt);
  assign set_w[`MIRB_REG_GRP_C] = group_set(grp_c_evt);

  // service clears the flag taken and the global enable
  always_comb begin
    for (int r = 0; r < `MIRB_NUM_REGS; r++) begin
      clr_w[r] = 8'h00;
      if (svc_take && src_reg(id_q) == 3'(r)) begin
        clr_w[r] = src_bit(id_q);  // R17
      end
    end
  end

  always_comb begin
    for (int r = 0; r < `MIRB_NUM_REGS; r++) begin
      regs_d[r] = regs_q[r];
      if (i_reg_wr && i_reg_addr == 3'(r)) begin
        regs_d[r] = i_reg_wdata;  // R17
      end
      regs_d[r] = ((regs_d[r] & ~clr_w[r]) | set_w[r]) & reg_mask(3'(r));  // R13 R16
    end
    if (svc_take) begin
      regs_d[`MIRB_REG_CTRL_A][`MIRB_GLOBAL_EN] = 1'b0;  // R15
    end
  end

  // pending sources in priority order
  wire logic [10:0] pend_w = {
    ctrl_c_w[`MIRB_UART_FLAG]   & ctrl_c_w[`MIRB_UART_EN] & uart_ok,
    ctrl_c_w[`MIRB_SERIAL_FLAG] & ctrl_c_w[`MIRB_SERIAL_EN],
    ctrl_b_w[`MIRB_NVM_FLAG]    & ctrl_b_w[`MIRB_NVM_EN],
    ctrl_b_w[`MIRB_ADC_FLAG]    & ctrl_b_w[`MIRB_ADC_EN],
    ctrl_c_w[`MIRB_GROUP2_FLAG] & ctrl_c_w[`MIRB_GROUP2_EN],
    ctrl_c_w[`MIRB_GROUP1_FLAG] & ctrl_c_w[`MIRB_GROUP1_EN],
    ctrl_b_w[`MIRB_GROUP0_FLAG] & ctrl_b_w[`MIRB_GROUP0_EN],
    ctrl_a_w[`MIRB_TICK_B_FLAG] & ctrl_a_w[`MIRB_TICK_B_EN],
    ctrl_a_w[`MIRB_TICK_A_FLAG] & ctrl_a_w[`MIRB_TICK_A_EN],
    ctrl_b_w[`MIRB_PIN_B_FLAG]  & ctrl_b_w[`MIRB_PIN_B_EN],
    ctrl_a_w[`MIRB_PIN_A_FLAG]  & ctrl_a_w[`MIRB_PIN_A_EN]
  };  // R14
  wire logic req_d = global_irq_en & (|pend_w) & ~svc_take;  // R4 R14

  wire mirb_byte_t rdata_d = (i_reg_rd && i_reg_addr < 3'(`MIRB_NUM_REGS))
                           ? regs_q[i_reg_addr] : 8'h00;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int r = 0; r < `MIRB_NUM_REGS; r++) begin
        regs_q[r] <= `MIRB_REG_RESET;
      end
      rdata_q <= 8'h00;
      req_q   <= 1'b0;
      id_q    <= MIRB_SRC_PIN_A;
    end else begin
      regs_q  <= regs_d;
      rdata_q <= rdata_d;
      req_q   <= req_d;
      id_q    <= first_src(pend_w);
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_irq_req   = req_q;
  assign o_irq_id    = id_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  AST_GLOBAL_BLOCKS: assert property (  // R4
    !global_irq_en |=> !o_irq_req)
    else $error("request raised with global enable clear");
  AST_REQ_NEEDS_ENABLE: assert property (  // R14
    o_irq_req |-> $past(global_irq_en) && $past(|pend_w))
    else $error("request without enabled pending source");
  AST_SVC_CLEARS_GLOBAL: assert property (  // R15
    i_svc_ack && o_irq_req |=> !global_irq_en ##1 !o_irq_req)
    else $error("global enable not cleared by service");
  AST_TICK_A_FLAG: assert property (  // R5
    i_tick_evt[0] |=> ctrl_a_w[`MIRB_TICK_A_FLAG])
    else $error("tick A event lost");
  AST_PIN_A_FLAG: assert property (  // R6
    edge_a.pulse |=> ctrl_a_w[`MIRB_PIN_A_FLAG])
    else $error("pin A edge lost");
  AST_PIN_B_FLAG: assert property (  // R7
    edge_b.pulse |=> ctrl_b_w[`MIRB_PIN_B_FLAG])
    else $error("pin B edge lost");
  AST_ADC_FLAG: assert property (  // R8
    i_adc_evt |=> ctrl_b_w[`MIRB_ADC_FLAG])
    else $error("converter event lost");
  AST_NVM_FLAG: assert property (  // R9
    i_nvm_evt |=> ctrl_b_w[`MIRB_NVM_FLAG])
    else $error("eeprom event lost");
  AST_GROUP0_FLAG: assert property (  // R10
    grp0_hit |=> ctrl_b_w[`MIRB_GROUP0_FLAG] && regs_q[`MIRB_REG_GRP_A][7:4] != 4'h0)
    else $error("group 0 event lost");
  AST_SERIAL_FLAG: assert property (  // R11
    i_serial_evt |=> ctrl_c_w[`MIRB_SERIAL_FLAG])
    else $error("serial event lost");
  AST_GROUP2_FLAG: assert property (  // R12
    grp2_hit |=> ctrl_c_w[`MIRB_GROUP2_FLAG])
    else $error("group 2 event lost");
  AST_NO_UART_BITS: assert property (  // R13
    (HAS_UART == 0) |-> ctrl_c_w[`MIRB_UART_FLAG] == 1'b0 && ctrl_c_w[`MIRB_UART_EN] == 1'b0)
    else $error("unimplemented control C bits set");
  AST_FLAG_HOLDS: assert property (  // R16 R17
    ctrl_b_w[`MIRB_ADC_FLAG] && !i_reg_wr && !svc_take |=> ctrl_b_w[`MIRB_ADC_FLAG])
    else $error("pending flag dropped");
  AST_TICK_B_FLAG: assert property (  // R5
    i_tick_evt[1] |=> ctrl_a_w[`MIRB_TICK_B_FLAG])
    else $error("tick B event lost");
  AST_GROUP1_FLAG: assert property (  // R12
    grp1_hit |=> ctrl_c_w[`MIRB_GROUP1_FLAG])
    else $error("group 1 event lost");

  // group registers latch every sub-event, enabled or not
  AST_GROUP_A_SUB_FLAG: assert property (  // R1
    i_group_evt[0] |=> regs_q[`MIRB_REG_GRP_A][`MIRB_SUB_FLAG_LSB])
    else $error("group A sub-event lost");
  AST_GROUP_B_SUB_FLAG: assert property (  // R1
    i_group_evt[7] |=> regs_q[`MIRB_REG_GRP_B][`MIRB_SUB_FLAG_LSB + 3])
    else $error("group B sub-event lost");
  AST_GROUP_C_SUB_FLAG: assert property (  // R1
    i_group_evt[11] |=> regs_q[`MIRB_REG_GRP_C][`MIRB_SUB_FLAG_LSB + 3])
    else $error("group C sub-event lost");

  // request and vector path
  AST_REQ_RISES: assert property (  // R14
    global_irq_en && (|pend_w) && !svc_take |=> o_irq_req)
    else $error("enabled pending source not requested");
  AST_PIN_A_FIRST: assert property (  // R14
    pend_w[0] |=> o_irq_id == MIRB_SRC_PIN_A)
    else $error("pin A not given first place");
  AST_SVC_DROPS_REQ: assert property (  // R15
    svc_take |=> !o_irq_req)
    else $error("request stands after service");
  AST_SVC_CLEARS_FLAG: assert property (  // R17
    svc_take && id_q == MIRB_SRC_ADC && !i_adc_evt |=> !ctrl_b_w[`MIRB_ADC_FLAG])
    else $error("serviced flag not cleared");

  // register bus
  AST_EDGE_WRITE: assert property (  // R2
    i_reg_wr && i_reg_addr == `MIRB_REG_EDGE
    |=> regs_q[`MIRB_REG_EDGE] == ($past(i_reg_wdata) & `MIRB_MASK_EDGE))
    else $error("edge select write lost");
  AST_READ_CTRL_A: assert property (  // R17
    i_reg_rd && i_reg_addr == `MIRB_REG_CTRL_A |=> o_reg_rdata == $past(ctrl_a_w))
    else $error("control A read wrong");
  AST_RDATA_IDLE: assert property (  // R17
    !i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data without a read");
endmodule : mirb_bank

`default_nettype wire

//--- logic/mirb_consts.svh
/*
  Constants of the interrupt register bank: register indices, bit
  positions, implemented-bit masks, reset values and edge codes.
  Assumes inclusion by bare name from the bank and its edge detector.
*/
// Summary of operation
// [R1] A source's event sets its request flag; software sets the enable bits.
// [R2] Edge select bits 3:2 pick pin B trigger: off, rising, falling, both.
// [R3] Edge select bits 1:0 pick pin A trigger with the same coding.
// [R4] Control A bit 0 is the global enable; zero blocks every interrupt.
// [R5] Control A: tick B/A flags at bits 6/5, enables at bits 3/2.
// [R6] Control A: pin A flag at bit 4, enable at bit 1.
// [R7] Control B: pin B flag at bit 7, enable at bit 3.
// [R8] Control B: converter flag at bit 6, enable at bit 2.
// [R9] Control B: data EEPROM flag at bit 5, enable at bit 1.
// [R10] Control B: group 0 flag at bit 4, enable at bit 0.
// [R11] Control C: serial interface flag at bit 6, enable at bit 2.
// [R12] Control C: group 2/1 flags at bits 5/4, enables at bits 1/0.
// [R13] Without the UART, control C bits 7 and 3 always read zero.
// [R14] An interrupt is taken only if flag, own enable and global enable are set.
// [R15] Entering service clears the global enable automatically.
// [R16] Requests arriving while blocked still set their flags and stay pending.
// [R17] Flags are read/write; stay set until written zero or serviced.
`ifndef MIRB_CONSTS_SVH
`define MIRB_CONSTS_SVH

`define MIRB_NUM_REGS      7
`define MIRB_REG_EDGE      3'h0
`define MIRB_REG_CTRL_A    3'h1
`define MIRB_REG_CTRL_B    3'h2
`define MIRB_REG_CTRL_C    3'h3
`define MIRB_REG_GRP_A     3'h4
`define MIRB_REG_GRP_B     3'h5
`define MIRB_REG_GRP_C     3'h6
`define MIRB_REG_RESET     8'h00

`define MIRB_MASK_EDGE     8'h0F
`define MIRB_MASK_CTRL_A   8'h7F
`define MIRB_MASK_FULL     8'hFF
`define MIRB_MASK_C_SMALL  8'h77

`define MIRB_PIN_B_SEL_LSB 2
`define MIRB_PIN_A_SEL_LSB 0

`define MIRB_GLOBAL_EN     0
`define MIRB_PIN_A_EN      1
`define MIRB_TICK_A_EN     2
`define MIRB_TICK_B_EN     3
`define MIRB_PIN_A_FLAG    4
`define MIRB_TICK_A_FLAG   5
`define MIRB_TICK_B_FLAG   6

`define MIRB_GROUP0_EN     0
`define MIRB_NVM_EN        1
`define MIRB_ADC_EN        2
`define MIRB_PIN_B_EN      3
`define MIRB_GROUP0_FLAG   4
`define MIRB_NVM_FLAG      5
`define MIRB_ADC_FLAG      6
`define MIRB_PIN_B_FLAG    7

`define MIRB_GROUP1_EN     0
`define MIRB_GROUP2_EN     1
`define MIRB_SERIAL_EN     2
`define MIRB_UART_EN       3
`define MIRB_GROUP1_FLAG   4
`define MIRB_GROUP2_FLAG   5
`define MIRB_SERIAL_FLAG   6
`define MIRB_UART_FLAG     7

`define MIRB_SUB_FLAG_LSB  4

`define MIRB_EDGE_OFF      2'h0
`define MIRB_EDGE_RISE     2'h1
`define MIRB_EDGE_FALL     2'h2
`define MIRB_EDGE_BOTH     2'h3

`endif

//--- logic/mirb_edge_det.sv
/*
  Edge detector for one external interrupt pin: two-flop synchroniser,
  then a one-cycle pulse on the edges the selector asks for.
  Assumes an asynchronous pin and the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mirb_consts.svh"

module mirb_edge_det (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_pin,
  mirb_edge_if.det  io_edge
);
  import mirb_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic pulse_q;
  logic rise_w;
  logic fall_w;
  logic pulse_d;

  assign rise_w  = sync2_q & ~prev_q;
  assign fall_w  = ~sync2_q & prev_q;
  assign pulse_d = ((io_edge.sel == `MIRB_EDGE_RISE) & rise_w)
                 | ((io_edge.sel == `MIRB_EDGE_FALL) & fall_w)
                 | ((io_edge.sel == `MIRB_EDGE_BOTH) & (rise_w | fall_w));  // R2 R3
  assign io_edge.pulse = pulse_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      pulse_q <= pulse_d;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  AST_EDGE_OFF_SILENT: assert property (  // R2
    (io_edge.sel == `MIRB_EDGE_OFF) |=> !pulse_q)
    else $error("pulse while detection is off");
  AST_EDGE_RISE: assert property (  // R3
    (io_edge.sel == `MIRB_EDGE_RISE) && $rose(sync2_q) |=> pulse_q)
    else $error("rising edge missed");
  AST_EDGE_FALL_ONLY: assert property (  // R3
    (io_edge.sel == `MIRB_EDGE_FALL) && $rose(sync2_q) |=> !pulse_q)
    else $error("rising edge taken in falling mode");
endmodule : mirb_edge_det

`default_nettype wire

//--- logic/mirb_edge_if.sv
/*
  Link between the register bank and one pin edge detector:
  trigger selector out, qualified edge pulse back.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface mirb_edge_if;
  logic [1:0] sel;
  logic       pulse;
  modport ctrl (output sel, input pulse);
  modport det  (input sel, output pulse);
endinterface : mirb_edge_if

`default_nettype wire

//--- logic/mirb_pkg.sv
/*
  Types of the interrupt register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package mirb_pkg;
  // vector source, listed from highest priority downward
  typedef enum logic [3:0] {
    MIRB_SRC_PIN_A,
    MIRB_SRC_PIN_B,
    MIRB_SRC_TICK_A,
    MIRB_SRC_TICK_B,
    MIRB_SRC_GROUP0,
    MIRB_SRC_GROUP1,
    MIRB_SRC_GROUP2,
    MIRB_SRC_ADC,
    MIRB_SRC_NVM,
    MIRB_SRC_SERIAL,
    MIRB_SRC_UART
  } mirb_src_t;

  typedef logic [7:0] mirb_byte_t;
endpackage : mirb_pkg

`default_nettype wire

//--- tb/mirb_core_model.sv
/*
  Model of the processor core side: takes the vector some cycles after
  the request rises and pulses the service acknowledge once.
  Assumes the bank's system clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module mirb_core_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_irq_req,
  input  wire logic       i_ack_en,
  input  wire logic [1:0] i_lag,
  output var  logic       o_svc_ack
);
  logic [1:0] cnt_q;

  // acks only while a request stands, once per request
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !i_irq_req || o_svc_ack) begin
      cnt_q     <= 2'h0;
      o_svc_ack <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 2'h1;
      o_svc_ack <= i_ack_en && (cnt_q == i_lag);
    end
  end
endmodule : mirb_core_model

`default_nettype wire

//--- tb/tb_top.sv
/*
  Self-checking bench of the interrupt register bank, small variant.
  Assumes the bank, its package and constants header compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mirb_consts.svh"

module tb_top;
  import mirb_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic [2:0]        addr      = 3'h0;
  logic              wr        = 1'b0;
  logic              rd        = 1'b0;
  logic [7:0]        wdata     = 8'h00;
  logic [7:0]        rdata;
  logic              pin_a     = 1'b0;
  logic              pin_b     = 1'b0;
  logic [17:0]       evt       = 18'h0;
  logic              svc_ack;
  logic              irq_req;
  mirb_src_t         irq_id;
  logic              ack_en    = 1'b0;
  logic [1:0]        lag       = 2'h0;
  int                fails     = 0;
  int                checks_done = 0;
  int                cyc       = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  mirb_bank #(.HAS_UART(0)) mirb_bank_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_ext_pin_a(pin_a),
    .i_ext_pin_b(pin_b), .i_tick_evt(evt[1:0]), .i_adc_evt(evt[2]), .i_nvm_evt(evt[3]),
    .i_serial_evt(evt[4]), .i_uart_evt(evt[5]), .i_group_evt(evt[17:6]),
    .i_svc_ack(svc_ack), .o_irq_req(irq_req), .o_irq_id(irq_id));

  mirb_core_model mirb_core_model_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_irq_req(irq_req),
    .i_ack_en(ack_en), .i_lag(lag), .o_svc_ack(svc_ack));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk); #1;
    addr = a; wdata = d; wr = 1'b1;
    @(posedge i_ref_clk); #1;
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_ref_clk); #1;
    addr = a; rd = 1'b1;
    @(posedge i_ref_clk); #1;
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (irq_req !== v && n < 20) begin
      @(posedge i_ref_clk); #1;
      n++;
    end
    chk(irq_req, v);
  endtask : wait_req

  task automatic t_reset_vals();
    for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
  endtask : t_reset_vals

  // all-ones written everywhere, unimplemented bits must read zero
  task automatic t_reg_map();
    logic [7:0] exp [8] = '{8'h0F, 8'h7F, 8'hFF, 8'h77, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    ack_en = 1'b0;
    for (int a = 0; a < 8; a++) wr_reg(a[2:0], 8'hFF);
    chk(irq_req, 1'b1);
    for (int a = 0; a < 8; a++) rd_chk(a[2:0], exp[a]);
    for (int a = 0; a < 8; a++) wr_reg(a[2:0], 8'h00);
  endtask : t_reg_map

  // each event but the UART one sets its own flag with all enables off, no request
  task automatic t_events();
    logic [2:0] a;
    logic [7:0] m;
    for (int i = 0; i < 18; i++) begin
      case (i)
        0: begin a = 3'h1; m = 8'h20; end
        1: begin a = 3'h1; m = 8'h40; end
        2: begin a = 3'h2; m = 8'h40; end
        3: begin a = 3'h2; m = 8'h20; end
        4: begin a = 3'h3; m = 8'h40; end
        5: begin a = 3'h3; m = 8'h00; end
        default: begin a = 3'(4 + (i - 6) / 4); m = 8'h10 << ((i - 6) % 4); end
      endcase
      @(posedge i_ref_clk); #1;
      evt[i] = 1'b1;
      @(posedge i_ref_clk); #1;
      evt = 18'h0;
      rd_chk(a, m);
      chk(irq_req, 1'b0);
      wr_reg(a, 8'h00);
    end
  endtask : t_events

  // enabled sub-events raise the primary flag, disabled ones only their own
  task automatic t_groups();
    wr_reg(3'h4, 8'h01);
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h6, 8'h08);
    @(posedge i_ref_clk);
    #1;
    evt[6] = 1'b1;
    evt[11] = 1'b1;
    evt[17] = 1'b1;
    @(posedge i_ref_clk);
    #1;
    evt = 18'h0;
    rd_chk(3'h2, 8'h10);
    rd_chk(3'h3, 8'h20);
    rd_chk(3'h4, 8'h11);
    rd_chk(3'h5, 8'h21);
    rd_chk(3'h6, 8'h88);
    chk(irq_req, 1'b0);
    for (int a = 2; a < 7; a++) wr_reg(a[2:0], 8'h00);
  endtask : t_groups

  // edge modes of both pins, rising then falling edge
  task automatic t_pins();
    logic [7:0] d;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(3'h0, 8'(m << (2 * (1 - p))));
        for (int e = 0; e < 2; e++) begin
          @(posedge i_ref_clk); #1;
          if (p == 0) pin_b = ~pin_b;
          else pin_a = ~pin_a;
          repeat (6) @(posedge i_ref_clk);
          rd_reg(p == 0 ? 3'h2 : 3'h1, d);
          chk(d, (m >> e) & 1 ? (p == 0 ? 8'h80 : 8'h10) : 8'h00);
          wr_reg(p == 0 ? 3'h2 : 3'h1, 8'h00);
        end
      end
    end
    wr_reg(3'h0, 8'h00);
  endtask : t_pins

  // pending converter flag waits for global enable, then service clears
  task automatic t_service(input logic [1:0] l);
    lag = l;
    ack_en = 1'b1;
    wr_reg(3'h2, 8'h04);
    @(posedge i_ref_clk); #1;
    evt[2] = 1'b1;
    @(posedge i_ref_clk); #1;
    evt = 18'h0;
    repeat (4) @(posedge i_ref_clk);
    chk(irq_req, 1'b0);
    rd_chk(3'h2, 8'h44);
    @(posedge i_ref_clk);
    #1;
    chk(rdata, 8'h00);
    wr_reg(3'h1, 8'h01);
    wait_req(1'b1);
    chk(8'(irq_id), 8'(MIRB_SRC_ADC));
    wait_req(1'b0);
    rd_chk(3'h1, 8'h00);
    rd_chk(3'h2, 8'h04);
    ack_en = 1'b0;
    wr_reg(3'h2, 8'h00);
  endtask : t_service

  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_sys_rst = 1'b0;
    t_reset_vals();
    t_reg_map();
    t_events();
    t_groups();
    t_pins();
    t_service(2'h0);
    t_service(2'h2);
    results();
  end
endmodule : tb_top

`default_nettype wire
